// [verilog/coc_pkg.sv]
// shared constants, types and helpers of the clock output channel control block
package coc_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 5;
	localparam int DIV_W = 8;
	localparam int DLY_W = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// ----------------------------------------------------------------
	// divider and delay encodings
	// ----------------------------------------------------------------
	localparam logic [DIV_W-1:0] DIV_BYPASS = 8'h00;
	localparam int DELAY_STEP_PS = 150;
	localparam int DELAY_MAX_PS = 2250;
	localparam int DELAY_MAX_CODE = DELAY_MAX_PS / DELAY_STEP_PS;

	// ----------------------------------------------------------------
	// synchronisation timing, in distribution clock cycles
	// ----------------------------------------------------------------
	localparam int SYNC_LATENCY = 4;
	localparam int SYNC_PIPE = SYNC_LATENCY - 2;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CH_FIRST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CH_LAST = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CH_DIV_LSB = 0;
	localparam int CH_DLY_LSB = 8;
	localparam int CH_EN_BIT = 12;
	localparam int GL_OE_BIT = 0;
	localparam int GL_LOCK_LSB = 1;
	localparam int GL_REF_LSB = 3;
	localparam int GL_LOSA_LSB = 5;
	localparam int GL_LOSB_LSB = 7;
	localparam int GL_BUFA_BIT = 9;
	localparam int GL_BUFB_BIT = 10;
	localparam int ST_LOCK1_BIT = 0;
	localparam int ST_LOCK2_BIT = 1;
	localparam int ST_LOSSA_BIT = 2;
	localparam int ST_LOSSB_BIT = 3;
	localparam int ST_REFSEL_BIT = 4;
	localparam int ST_HOLD_BIT = 5;
	localparam int ST_GOE_BIT = 6;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [DIV_W-1:0] CH_DIV_RST = 8'h01;
	localparam logic [DLY_W-1:0] CH_DLY_RST = 4'h0;
	localparam logic CH_EN_RST = 1'b0;
	localparam logic GL_OE_RST = 1'b1;

	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {LOCK_BOTH, LOCK_FIRST, LOCK_SECOND} coc_lock_e;
	typedef enum logic [1:0] {REF_FIX_A, REF_FIX_B, REF_AUTO_REVERT, REF_AUTO_HOLD} coc_ref_e;
	typedef enum logic [1:0] {LOS_PUSH_PULL, LOS_NMOS_OD, LOS_PMOS_OD} coc_los_e;

	// last count of a divide-by-2k half period
	function automatic logic [DIV_W-1:0] div_last(input logic [DIV_W-1:0] k);
		div_last = k - 8'h01;
	endfunction

	// pin drive {level, enable} of one loss output for its electrical mode
	function automatic logic [1:0] los_drive(input coc_los_e t, input logic loss);
		case (t)
			LOS_NMOS_OD: los_drive = {1'b0, loss};
			LOS_PMOS_OD: los_drive = {1'b1, loss};
			default: los_drive = {loss, 1'b1};
		endcase
	endfunction

endpackage

// [verilog/coc_channel.sv]
// one output channel: even divider with bypass and synchronous restart
`timescale 1ns/1ps
module coc_channel
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic hold_i,
	input wire logic [coc_pkg::DIV_W-1:0] div_i,
	output logic q_o
);
	import coc_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic q;
		logic [DIV_W-1:0] since;
		logic [DIV_W-1:0] div_seen;
	} coc_chan_s;

	coc_chan_s state_ff;
	coc_chan_s nxt_state;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	// hold parks every channel one count before its first rising edge
	always_comb
	begin
		nxt_state = state_ff;
		if (hold_i)
		begin
			nxt_state.q = 1'b0;
			nxt_state.cnt = (div_i == DIV_BYPASS) ? '0 : div_last(div_i);
		end
		else if (div_i == DIV_BYPASS)
		begin
			nxt_state.q = 1'b1;
		end
		else if (state_ff.cnt >= div_last(div_i))
		begin
			nxt_state.cnt = '0;
			nxt_state.q = ~state_ff.q;
		end
		else
		begin
			nxt_state.cnt = state_ff.cnt + 8'h01;
		end
		// cycles since the last edge, only for checking the ratio; all ones marks a half
		// period begun under an older divide setting, which a ratio check must not judge
		nxt_state.div_seen = div_i;
		if (hold_i || nxt_state.q != state_ff.q)
			nxt_state.since = '0;
		else if (div_i != state_ff.div_seen)
			nxt_state.since = 8'hFF;
		else if (state_ff.since != 8'hFF)
			nxt_state.since = state_ff.since + 8'h01;
	end

	// state register
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign q_o = state_ff.q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	div_ratio_a: assert property ($changed(q_o) && !$past(hold_i, 2) && !$past(hold_i) && $stable(div_i)
		&& $past(div_i) == $past(state_ff.div_seen) && $past(state_ff.since) != 8'hFF
		&& div_i != DIV_BYPASS |-> $past(state_ff.since) == div_last(div_i))
		else $error("channel half period differs from divide setting");
	hold_park_a: assert property (hold_i |=> !q_o && state_ff.cnt == (div_i == DIV_BYPASS ? 8'h00 : div_last(div_i)))
		else $error("channel not parked while held");
	bypass_pass_a: assert property (div_i == DIV_BYPASS && !hold_i |=> q_o)
		else $error("bypass channel not passing the clock");

endmodule

// [verilog/coc_clock_output_ctrl.sv]
// top of the clock output channel control: registers, sync, enables, lock and reference logic
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module coc_clock_output_ctrl
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic [coc_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [coc_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [coc_pkg::DATA_W-1:0] RDATA_O,
	input wire logic SYNC_N_I,
	input wire logic GLOBAL_OUTPUT_ENABLE_PIN_I,
	input wire logic FIRST_LOOP_LOCK_I,
	input wire logic SECOND_LOOP_LOCK_I,
	input wire logic REF_INPUT_A_LOSS_I,
	input wire logic REF_INPUT_B_LOSS_I,
	output logic [coc_pkg::NUM_CH-1:0] CLK_OUT_O,
	output logic [coc_pkg::NUM_CH-1:0] CLK_OUT_OE_O,
	output logic [coc_pkg::NUM_CH-1:0] CH_BYPASS_O,
	output logic [coc_pkg::NUM_CH*coc_pkg::DLY_W-1:0] CHANNEL_DELAY_SETTING_O,
	output logic LOCK_INDICATOR_O,
	output logic REF_SEL_O,
	output logic [1:0] REF_LOSS_INDICATOR_O,
	output logic [1:0] REF_LOSS_INDICATOR_OE_O,
	output logic [1:0] REF_BUFTYPE_O
);
	import coc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_CH-1:0][DIV_W-1:0] div;
		logic [NUM_CH-1:0][DLY_W-1:0] dly;
		logic [NUM_CH-1:0] en;
		logic glob_oe;
		coc_lock_e lock_sel;
		coc_ref_e ref_mode;
		coc_los_e los_type_a;
		coc_los_e los_type_b;
		logic [1:0] buftype;
		logic sync_meta;
		logic sync_s;
		logic [SYNC_PIPE-1:0] sync_pipe;
		logic goe_meta;
		logic goe_s;
		logic [1:0] lock_meta;
		logic [1:0] lock_s;
		logic [1:0] loss_meta;
		logic [1:0] loss_s;
		logic ref_sel;
		logic [NUM_CH-1:0] clk_out;
		logic [NUM_CH-1:0] clk_oe;
		logic [NUM_CH-1:0] byp;
		logic lock_ind;
		logic [1:0] los_out;
		logic [1:0] los_oe;
		logic [DATA_W-1:0] rdata;
	} coc_top_s;

	coc_top_s state_ff;
	coc_top_s nxt_state;
	logic [NUM_CH-1:0] ch_q;
	logic hold;
	logic ch_addr;
	logic [2:0] ch_idx;
	logic auto_mode;

	// ----------------------------------------------------------------
	// channel dividers
	// ----------------------------------------------------------------
	// every channel sees the same hold so they restart in step
	assign hold = ~state_ff.sync_pipe[SYNC_PIPE-1];
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		coc_channel u_channel
		(
			.clk_i(CLK_I),
			.nrst_i(NRST_I),
			.hold_i(hold),
			.div_i(state_ff.div[g]),
			.q_o(ch_q[g])
		);
	end

	// register decode helpers
	assign ch_addr = (ADDR_I <= ADDR_CH_LAST) && (ADDR_I[1:0] == 2'b00);
	assign ch_idx = ADDR_I[4:2] - ADDR_CH_FIRST[4:2];
	assign auto_mode = (state_ff.ref_mode == REF_AUTO_REVERT) || (state_ff.ref_mode == REF_AUTO_HOLD);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;

		// pins from outside the clock domain pass two flops first
		nxt_state.sync_meta = SYNC_N_I;
		nxt_state.sync_s = state_ff.sync_meta;
		// a low shorter than a cycle may be missed, hence the pulse width demand on the driver
		nxt_state.sync_pipe = {state_ff.sync_pipe[SYNC_PIPE-2:0], state_ff.sync_s};
		nxt_state.goe_meta = GLOBAL_OUTPUT_ENABLE_PIN_I;
		nxt_state.goe_s = state_ff.goe_meta;
		nxt_state.lock_meta = {SECOND_LOOP_LOCK_I, FIRST_LOOP_LOCK_I};
		nxt_state.lock_s = state_ff.lock_meta;
		nxt_state.loss_meta = {REF_INPUT_B_LOSS_I, REF_INPUT_A_LOSS_I};
		nxt_state.loss_s = state_ff.loss_meta;

		// register writes
		if (WR_I && ch_addr)
		begin
			nxt_state.div[ch_idx] = WDATA_I[CH_DIV_LSB +: DIV_W];
			nxt_state.dly[ch_idx] = WDATA_I[CH_DLY_LSB +: DLY_W];
			nxt_state.en[ch_idx] = WDATA_I[CH_EN_BIT];
		end
		else if (WR_I && ADDR_I == ADDR_GLOBAL)
		begin
			nxt_state.glob_oe = WDATA_I[GL_OE_BIT];
			nxt_state.lock_sel = coc_lock_e'(WDATA_I[GL_LOCK_LSB +: 2]);
			nxt_state.ref_mode = coc_ref_e'(WDATA_I[GL_REF_LSB +: 2]);
			nxt_state.los_type_a = coc_los_e'(WDATA_I[GL_LOSA_LSB +: 2]);
			nxt_state.los_type_b = coc_los_e'(WDATA_I[GL_LOSB_LSB +: 2]);
			nxt_state.buftype = {WDATA_I[GL_BUFB_BIT], WDATA_I[GL_BUFA_BIT]};
		end

		// register reads: data stand for one cycle only, unmapped reads give zero
		nxt_state.rdata = '0;
		if (RD_I && ch_addr)
		begin
			nxt_state.rdata[CH_DIV_LSB +: DIV_W] = state_ff.div[ch_idx];
			nxt_state.rdata[CH_DLY_LSB +: DLY_W] = state_ff.dly[ch_idx];
			nxt_state.rdata[CH_EN_BIT] = state_ff.en[ch_idx];
		end
		else if (RD_I && ADDR_I == ADDR_GLOBAL)
		begin
			nxt_state.rdata[GL_OE_BIT] = state_ff.glob_oe;
			nxt_state.rdata[GL_LOCK_LSB +: 2] = state_ff.lock_sel;
			nxt_state.rdata[GL_REF_LSB +: 2] = state_ff.ref_mode;
			nxt_state.rdata[GL_LOSA_LSB +: 2] = state_ff.los_type_a;
			nxt_state.rdata[GL_LOSB_LSB +: 2] = state_ff.los_type_b;
			nxt_state.rdata[GL_BUFA_BIT] = state_ff.buftype[0];
			nxt_state.rdata[GL_BUFB_BIT] = state_ff.buftype[1];
		end
		else if (RD_I && ADDR_I == ADDR_STATUS)
		begin
			nxt_state.rdata[ST_LOCK1_BIT] = state_ff.lock_s[0];
			nxt_state.rdata[ST_LOCK2_BIT] = state_ff.lock_s[1];
			nxt_state.rdata[ST_LOSSA_BIT] = state_ff.loss_s[0];
			nxt_state.rdata[ST_LOSSB_BIT] = state_ff.loss_s[1];
			nxt_state.rdata[ST_REFSEL_BIT] = state_ff.ref_sel;
			nxt_state.rdata[ST_HOLD_BIT] = hold;
			nxt_state.rdata[ST_GOE_BIT] = state_ff.goe_s;
		end

		// output gating: divider, then enable bits and pin, then bypass flag beside it
		for (int i = 0; i < NUM_CH; i++)
		begin
			nxt_state.clk_oe[i] = state_ff.en[i] & state_ff.glob_oe;
			// a low pin drives the output low rather than floating it
			nxt_state.clk_out[i] = ch_q[i] & nxt_state.clk_oe[i] & state_ff.goe_s;
			nxt_state.byp[i] = (state_ff.div[i] == DIV_BYPASS);
		end

		// lock indicator source
		case (state_ff.lock_sel)
			LOCK_FIRST: nxt_state.lock_ind = state_ff.lock_s[0];
			LOCK_SECOND: nxt_state.lock_ind = state_ff.lock_s[1];
			default: nxt_state.lock_ind = &state_ff.lock_s;
		endcase

		// reference selection; the holding mode stays put until the current input fails
		case (state_ff.ref_mode)
			REF_FIX_A: nxt_state.ref_sel = 1'b0;
			REF_FIX_B: nxt_state.ref_sel = 1'b1;
			REF_AUTO_REVERT: nxt_state.ref_sel = state_ff.loss_s[0] & ~state_ff.loss_s[1];
			default:
			begin
				if (state_ff.ref_sel ? (state_ff.loss_s[1] & ~state_ff.loss_s[0])
					: (state_ff.loss_s[0] & ~state_ff.loss_s[1]))
					nxt_state.ref_sel = ~state_ff.ref_sel;
			end
		endcase

		// loss outputs only report the selected input, and only in automatic modes
		{nxt_state.los_out[0], nxt_state.los_oe[0]} = los_drive(state_ff.los_type_a,
			auto_mode & ~state_ff.ref_sel & state_ff.loss_s[0]);
		{nxt_state.los_out[1], nxt_state.los_oe[1]} = los_drive(state_ff.los_type_b,
			auto_mode & state_ff.ref_sel & state_ff.loss_s[1]);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// sync and enable pins reset to their released level, matching the pull-up
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			state_ff <= '0;
			state_ff.div <= {NUM_CH{CH_DIV_RST}};
			state_ff.dly <= {NUM_CH{CH_DLY_RST}};
			state_ff.en <= {NUM_CH{CH_EN_RST}};
			state_ff.glob_oe <= GL_OE_RST;
			state_ff.lock_sel <= LOCK_BOTH;
			state_ff.ref_mode <= REF_FIX_A;
			state_ff.los_type_a <= LOS_PUSH_PULL;
			state_ff.los_type_b <= LOS_PUSH_PULL;
			state_ff.sync_meta <= 1'b1;
			state_ff.sync_s <= 1'b1;
			state_ff.sync_pipe <= '1;
			state_ff.goe_meta <= 1'b1;
			state_ff.goe_s <= 1'b1;
			state_ff.los_oe <= 2'b11;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign RDATA_O = state_ff.rdata;
	assign CLK_OUT_O = state_ff.clk_out;
	assign CLK_OUT_OE_O = state_ff.clk_oe;
	assign CH_BYPASS_O = state_ff.byp;
	assign CHANNEL_DELAY_SETTING_O = state_ff.dly;
	assign LOCK_INDICATOR_O = state_ff.lock_ind;
	assign REF_SEL_O = state_ff.ref_sel;
	assign REF_LOSS_INDICATOR_O = state_ff.los_out;
	assign REF_LOSS_INDICATOR_OE_O = state_ff.los_oe;
	assign REF_BUFTYPE_O = state_ff.buftype;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	sequence sync_low_seq;
		!state_ff.sync_s [*4];
	endsequence

	sequence sync_release_seq;
		sync_low_seq ##1 state_ff.sync_s [*4];
	endsequence

	sync_hold_a: assert property ($fell(state_ff.sync_s) |-> ##4 (CLK_OUT_O == '0))
		else $error("outputs not low four cycles after sync registered");
	sync_edge_a: assert property (sync_release_seq |-> CLK_OUT_O == '0)
		else $error("outputs left low state early after sync release");
	sync_rise_a: assert property (sync_release_seq |=> CLK_OUT_O == (CLK_OUT_OE_O & {NUM_CH{$past(state_ff.goe_s)}}))
		else $error("active outputs did not rise together after sync release");
	glob_off_a: assert property (!state_ff.glob_oe |=> CLK_OUT_OE_O == '0)
		else $error("channel enabled while global enable bit is clear");
	goe_low_a: assert property (!state_ff.goe_s |=> CLK_OUT_O == '0)
		else $error("output high while enable pin is low");
	lock_both_a: assert property (state_ff.lock_sel == LOCK_BOTH |=> LOCK_INDICATOR_O == $past(&state_ff.lock_s))
		else $error("lock indicator wrong in both-loops mode");
	ref_fixed_a: assert property (state_ff.ref_mode == REF_FIX_B ##1 state_ff.ref_mode == REF_FIX_B |-> REF_SEL_O)
		else $error("fixed reference b not selected");
	los_manual_a: assert property (state_ff.ref_mode == REF_FIX_A && state_ff.los_type_a == LOS_PUSH_PULL
		|=> !REF_LOSS_INDICATOR_O[0] && REF_LOSS_INDICATOR_OE_O[0])
		else $error("loss reported outside automatic mode");
	read_idle_a: assert property (!RD_I |=> RDATA_O == '0)
		else $error("read data present without a read");
	rd_unmapped_a: assert property (RD_I && ADDR_I > ADDR_STATUS |=> RDATA_O == '0)
		else $error("read beyond the map returned data");

	// hold seen on two edges: the dividers have parked and the output flops follow one edge later
	sequence held_seq;
		hold [*2];
	endsequence

	held_low_a: assert property (held_seq |=> CLK_OUT_O == '0)
		else $error("outputs not low while sync is held");

	// ----------------------------------------------------------------
	// checks: enables and gating
	// ----------------------------------------------------------------
	oe_gate_a: assert property (CLK_OUT_OE_O == $past(state_ff.en & {NUM_CH{state_ff.glob_oe}}))
		else $error("drive enable does not follow the enable bits");
	float_off_a: assert property ((CLK_OUT_O & ~CLK_OUT_OE_O) == '0)
		else $error("output high on a channel that is not driven");
	pin_gate_a: assert property (CLK_OUT_O
		== $past(ch_q & state_ff.en & {NUM_CH{state_ff.glob_oe & state_ff.goe_s}}))
		else $error("output level does not follow divider and enables");
	// the flag lags the divide code by one edge, so the pad mux never sees a half-written code
	bypass_flag_a: assert property (WR_I && ADDR_I == ADDR_CH_FIRST |=> ##1 CH_BYPASS_O[0]
		== ($past(WDATA_I[CH_DIV_LSB +: DIV_W], 2) == DIV_BYPASS))
		else $error("bypass flag does not follow the divide code");
	delay_code_a: assert property (WR_I && ADDR_I == ADDR_CH_FIRST
		|=> CHANNEL_DELAY_SETTING_O[DLY_W-1:0] == $past(WDATA_I[CH_DLY_LSB +: DLY_W]))
		else $error("delay code of channel 0 not taken from the write");

	// ----------------------------------------------------------------
	// checks: lock, reference and loss outputs
	// ----------------------------------------------------------------
	lock_first_a: assert property (state_ff.lock_sel == LOCK_FIRST
		|=> LOCK_INDICATOR_O == $past(state_ff.lock_s[0]))
		else $error("lock indicator wrong in first-loop mode");
	lock_second_a: assert property (state_ff.lock_sel == LOCK_SECOND
		|=> LOCK_INDICATOR_O == $past(state_ff.lock_s[1]))
		else $error("lock indicator wrong in second-loop mode");
	lock_spare_a: assert property (state_ff.lock_sel == 2'h3
		|=> LOCK_INDICATOR_O == $past(&state_ff.lock_s))
		else $error("spare lock code does not act as both loops");
	ref_default_a: assert property (state_ff.ref_mode == REF_FIX_A |=> !REF_SEL_O)
		else $error("fixed reference a not selected");
	ref_revert_a: assert property (state_ff.ref_mode == REF_AUTO_REVERT
		|=> REF_SEL_O == $past(state_ff.loss_s[0] & ~state_ff.loss_s[1]))
		else $error("revertive selection wrong");
	// holding mode must not leave an input that still has signal
	ref_hold_a: assert property (state_ff.ref_mode == REF_AUTO_HOLD && !state_ff.loss_s[state_ff.ref_sel]
		|=> $stable(REF_SEL_O))
		else $error("holding selection left a good input");
	los_nmos_a: assert property (state_ff.los_type_a == LOS_NMOS_OD |=> !REF_LOSS_INDICATOR_O[0])
		else $error("nmos loss output drives high");
	los_pmos_a: assert property (state_ff.los_type_b == LOS_PMOS_OD |=> REF_LOSS_INDICATOR_O[1])
		else $error("pmos loss output drives low");
	los_report_a: assert property (auto_mode && !state_ff.ref_sel && state_ff.los_type_a == LOS_PUSH_PULL
		|=> REF_LOSS_INDICATOR_O[0] == $past(state_ff.loss_s[0]))
		else $error("selected input loss not reported");
	buf_type_a: assert property (WR_I && ADDR_I == ADDR_GLOBAL
		|=> REF_BUFTYPE_O == {$past(WDATA_I[GL_BUFB_BIT]), $past(WDATA_I[GL_BUFA_BIT])})
		else $error("buffer type bits not taken from the write");

endmodule

// [tb/coc_far_side.sv]
// far side model: sync driver and the wiring of the global enable pin
`timescale 1ns/1ps
module coc_far_side
(
	input wire logic sync_req_i,
	input wire logic [1:0] goe_mode_i,
	input wire logic lock_ind_i,
	output logic sync_n_o,
	output logic goe_o
);
	// the bench holds each request for many cycles, well past one clock period
	assign sync_n_o = !sync_req_i;
	// mode 0 leaves the pin open so the pull-up reads high, mode 2 ties the lock indicator to it
	assign goe_o = (goe_mode_i == 2'h0) ? 1'h1 : (goe_mode_i == 2'h2) ? lock_ind_i : 1'h0;
endmodule

// [tb/coc_clock_output_ctrl_tb.sv]
// self-checking bench of the clock output channel control block
`timescale 1ns/1ps
module coc_clock_output_ctrl_tb;
	import coc_pkg::*;
	logic clk, nrst, wr, rd, sync_req, sync_n, global_output_enable_pin, lock1, lock2, loss_a, loss_b, lock_ind, ref_sel, hi;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, q;
	logic [1:0] goe_mode, loss_pin, loss_oe, buf_type, bufs, elev, eoe;
	logic [NUM_CH-1:0] clk_out, clk_oe, bypass;
	logic [NUM_CH*DLY_W-1:0] dly, ed;
	logic [3:0] dcode [NUM_CH];
	int kdiv [NUM_CH] = '{1, 3, 0, 255, 2};
	int fall [NUM_CH];
	int fail_count, n_compared, m, n, t, sel, mode, ty;

	// ----------------------------------------------------------------
	// clock, far side and design
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	coc_far_side far (.sync_req_i(sync_req), .goe_mode_i(goe_mode), .lock_ind_i(lock_ind),
		.sync_n_o(sync_n), .goe_o(global_output_enable_pin));

	coc_clock_output_ctrl dut (.CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .SYNC_N_I(sync_n), .GLOBAL_OUTPUT_ENABLE_PIN_I(global_output_enable_pin),
		.FIRST_LOOP_LOCK_I(lock1), .SECOND_LOOP_LOCK_I(lock2), .REF_INPUT_A_LOSS_I(loss_a),
		.REF_INPUT_B_LOSS_I(loss_b), .CLK_OUT_O(clk_out), .CLK_OUT_OE_O(clk_oe), .CH_BYPASS_O(bypass),
		.CHANNEL_DELAY_SETTING_O(dly), .LOCK_INDICATOR_O(lock_ind), .REF_SEL_O(ref_sel),
		.REF_LOSS_INDICATOR_O(loss_pin), .REF_LOSS_INDICATOR_OE_O(loss_oe), .REF_BUFTYPE_O(buf_type));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one bus cycle, then an idle cycle so strobes never get two drives in one step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		rd <= 1'h0;
		#1 q = rdata;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	// reference selection model; hold mode keeps its choice until the current input is lost
	task automatic upd(input int a, input int b);
		if (mode < 2)
			sel = mode;
		else if (mode == 2)
			sel = a & !b;
		else if ((sel ? b : a) && !(sel ? a : b))
			sel = !sel;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		nrst = 1'h0;
		{wr, rd, sync_req, lock1, lock2, loss_a, loss_b} = 7'h00;
		addr = '0;
		wdata = '0;
		goe_mode = 2'h0;
		fail_count = 0;
		n_compared = 0;
		sel = 0;
		void'($urandom(32'hA50F40D9));
		repeat (10) @(posedge clk);
		nrst <= 1'h1;
		// reset contents and an unmapped read
		bus(1'h0, ADDR_CH_FIRST, '0);
		chk("ch0 reset", q, {19'h0, CH_EN_RST, CH_DLY_RST, CH_DIV_RST});
		bus(1'h0, ADDR_GLOBAL, '0);
		chk("global reset", q, 32'h1);
		bus(1'h0, 8'h1C, '0);
		chk("unmapped", q, 32'h0);
		// program ratios 2, 6, bypass, 510 and a disabled channel with random delays
		for (int i = 0; i < NUM_CH; i++)
		begin
			dcode[i] = 4'($urandom_range(DELAY_MAX_CODE, 0));
			ed[4*i +: 4] = dcode[i];
			bus(1'h1, 8'(4*i), {19'h0, i < 4, dcode[i], 8'(kdiv[i])});
		end
		@(posedge clk);
		sync_req <= 1'h1;
		tick(6);
		chk("held low", clk_out, 5'h00);
		chk("delay codes", dly, ed);
		chk("bypass", bypass, 5'h04);
		chk("drive enables", clk_oe, 5'h0F);
		// status while held: hold bit and released enable pin, nothing else
		bus(1'h0, ADDR_STATUS, '0);
		chk("status held", q, 32'h60);
		// release: two synchroniser edges plus four cycles to the common rising edge
		@(posedge clk);
		sync_req <= 1'h0;
		for (n = 1; n < 20; n++)
		begin
			tick(1);
			if (clk_out !== 5'h00)
				break;
		end
		chk("release latency", n, 6);
		chk("first rise", clk_out, 5'h0F);
		if (n == 20)
			wrap_up();
		fall = '{default: 0};
		for (t = 1; t <= 600; t++)
		begin
			tick(1);
			for (int i = 0; i < NUM_CH; i++)
				if (fall[i] == 0 && clk_out[i] === 1'h0)
					fall[i] = t;
		end
		for (int i = 0; i < NUM_CH; i++)
			chk("half period", fall[i], kdiv[i] == 0 ? 0 : (i < 4 ? kdiv[i] : 1));
		// gating table on channel 0, last two rows with the lock indicator wired to the pin
		for (m = 0; m < 10; m++)
		begin
			bus(1'h1, ADDR_CH_FIRST, {19'h0, m[0] | m[3], 12'h001});
			bus(1'h1, ADDR_GLOBAL, {31'h0, m[1] | m[3]});
			@(posedge clk);
			goe_mode <= m[3] ? 2'h2 : {1'h0, !m[2]};
			lock1 <= m[0];
			lock2 <= 1'h1;
			tick(8);
			hi = 1'h0;
			for (t = 0; t < 4; t++)
			begin
				tick(1);
				hi = hi | clk_out[0];
			end
			chk("ch0 running", hi, m[3] ? m[0] : m[0] & m[1] & m[2]);
			chk("ch0 drive", clk_oe[0], m[3] | m[0] & m[1]);
		end
		@(posedge clk);
		goe_mode <= 2'h0;
		// lock indicator sources, every code with every lock pair
		for (m = 0; m < 16; m++)
		begin
			bus(1'h1, ADDR_GLOBAL, {29'h0, m[3:2], 1'h1});
			@(posedge clk);
			lock1 <= m[0];
			lock2 <= m[1];
			tick(4);
			chk("lock", lock_ind, m[3:2] == 1 ? m[0] : m[3:2] == 2 ? m[1] : m[0] & m[1]);
		end
		// reference modes, loss output types and buffer types with random losses
		for (m = 0; m < 64; m++)
		begin
			bufs = 2'($urandom);
			mode = m >> 4;
			bus(1'h1, ADDR_GLOBAL, {21'h0, bufs, 4'(m), 2'(m >> 4), 3'h1});
			upd(loss_a, loss_b);
			@(posedge clk);
			loss_a <= 1'($urandom);
			loss_b <= 1'($urandom);
			tick(4);
			upd(loss_a, loss_b);
			for (int i = 0; i < 2; i++)
			begin
				hi = mode >= 2 && sel == i && (i ? loss_b : loss_a);
				ty = (m >> (2*i)) & 3;
				elev[i] = ty == 2 || (ty != 1 && hi);
				eoe[i] = (ty == 1 || ty == 2) ? hi : 1'h1;
			end
			chk("ref select", ref_sel, sel[0]);
			chk("loss level", loss_pin, elev);
			chk("loss drive", loss_oe, eoe);
			chk("buffer type", buf_type, bufs);
			bus(1'h0, ADDR_STATUS, '0);
			chk("status", q & 32'h5F, {25'h0, 2'h2, sel[0], loss_b, loss_a, lock2, lock1});
		end
		wrap_up();
	end
endmodule
